// ---- src/swl_link.v ----
// Contract
// - The single-wire link is an option sharing the two-wire data pin.
// - Once single-wire mode is chosen it stays chosen until power-up.
// - Device bit periods last 190 to 250 us, nominally 205 us.
// - A host low of at least 2.2 s on the line resets the device.
`include "swl_regs.vh"
module swl_link #(
    // Cycles per microsecond; a test may shrink it to keep runs short
    parameter US_CYCLES  = `SWL_US_CYCLES,
    parameter RST_CYCLES = `SWL_N_RST
) (
    input  wire       mclk_i,
    input  wire       rst_b_i,
    input  wire       sel_single_wire_i,
    input  wire       single_wire_data_line_i,
    output reg        single_wire_data_line_o,
    output reg        single_wire_data_line_oe_o,
    output reg        single_wire_mode_o,
    output reg        cmd_valid_o,
    output reg  [6:0] cmd_addr_o,
    output reg        cmd_write_o,
    output reg  [7:0] wr_data_o,
    input  wire [7:0] rd_data_i,
    output reg        device_reset_o
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_BREAK = 3'd1;
    localparam [2:0] ST_RXBIT = 3'd2;
    localparam [2:0] ST_WAIT  = 3'd3;
    localparam [2:0] ST_TXBIT = 3'd4;

    localparam [31:0] N_BREAK  = `SWL_T_BREAK_US * US_CYCLES;
    localparam [31:0] N_BRREC  = `SWL_T_BREAK_REC_US * US_CYCLES;
    localparam [31:0] N_SPLIT  = `SWL_T_SPLIT_US * US_CYCLES;
    localparam [31:0] N_CYCD   = `SWL_T_CYCD_US * US_CYCLES;
    localparam [31:0] N_DW1    = `SWL_T_DW1_US * US_CYCLES;
    localparam [31:0] N_DW0    = `SWL_T_DW0_US * US_CYCLES;
    localparam [31:0] N_RSPS   = `SWL_T_RSPS_US * US_CYCLES;
    localparam [31:0] N_RST    = RST_CYCLES;

    wire       line;
    reg        line_d;
    reg  [2:0] state;
    reg [31:0] cnt;
    reg [31:0] low_cnt;
    reg  [4:0] bit_idx;
    reg [15:0] shreg;
    reg  [7:0] tx_byte;
    reg        armed;

    wire fall = line_d & ~line;
    wire rise = ~line_d & line;

    // ----------------------------------------------------------------
    // Bit decode
    // ----------------------------------------------------------------
    // Short low is a one; valid at the rise that ends the pulse
    wire rx_bit = (cnt < N_SPLIT);

    // ----------------------------------------------------------------
    // Pin input, shared with the two-wire data pin
    // ----------------------------------------------------------------
    swl_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .din_i   (single_wire_data_line_i),
        .dout_o  (line)
    );

    // ----------------------------------------------------------------
    // Mode latch and long-low reset
    // ----------------------------------------------------------------
    // Mode is sticky: only reset clears it, a low line never does
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            single_wire_mode_o <= 1'b0;
            low_cnt            <= 32'd0;
            device_reset_o     <= 1'b0;
            line_d             <= 1'b1;
        end else begin
            line_d <= line;
            if (sel_single_wire_i) begin
                single_wire_mode_o <= 1'b1;
            end
            // Counter saturates, so a held line gives one reset pulse
            if (line || single_wire_data_line_oe_o) begin
                low_cnt <= 32'd0;
            end else if (low_cnt != N_RST) begin
                low_cnt <= low_cnt + 32'd1;
            end
            device_reset_o <= single_wire_mode_o &&
                              (low_cnt == N_RST - 32'd1);
        end
    end

    // ----------------------------------------------------------------
    // Protocol engine
    // ----------------------------------------------------------------
    // Half duplex line: one engine serves both directions
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state                      <= ST_IDLE;
            cnt                        <= 32'd0;
            bit_idx                    <= 5'd0;
            shreg                      <= 16'h0000;
            tx_byte                    <= 8'h00;
            armed                      <= 1'b0;
            cmd_valid_o                <= 1'b0;
            cmd_addr_o                 <= 7'h00;
            cmd_write_o                <= 1'b0;
            wr_data_o                  <= 8'h00;
            single_wire_data_line_o    <= 1'b1;
            single_wire_data_line_oe_o <= 1'b0;
        end else begin
            cmd_valid_o <= 1'b0;
            cnt         <= cnt + 32'd1;
            if (!single_wire_mode_o || device_reset_o) begin
                state                      <= ST_IDLE;
                single_wire_data_line_oe_o <= 1'b0;
            end else begin
                case (state)
                ST_IDLE: begin
                    // Any fall may open a break; short ones drop back here
                    if (fall) begin
                        cnt   <= 32'd0;
                        armed <= 1'b0;
                        state <= ST_BREAK;
                    end
                end
                ST_BREAK: begin
                    // Break low, then recovery high before first bit
                    if (!line && cnt >= N_BREAK) begin
                        armed <= 1'b1;
                    end
                    if (rise) begin
                        if (!armed) begin
                            state <= ST_IDLE;
                        end
                        cnt <= 32'd0;
                    end
                    if (fall && line_d && armed) begin
                        if (cnt >= N_BRREC) begin
                            cnt     <= 32'd0;
                            bit_idx <= 5'd0;
                            state   <= ST_RXBIT;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_RXBIT: begin
                    // Pulse width decides the bit; LSB first
                    if (rise) begin
                        shreg   <= {rx_bit, shreg[15:1]};
                        bit_idx <= bit_idx + 5'd1;
                        if (bit_idx == 5'd7 && !rx_bit) begin
                            // Read command complete; new bit is the rw flag
                            cmd_addr_o  <= shreg[15:9];
                            cmd_write_o <= 1'b0;
                            cmd_valid_o <= 1'b1;
                            cnt         <= 32'd0;
                            state       <= ST_WAIT;
                        end else if (bit_idx == 5'd15) begin
                            cmd_addr_o  <= shreg[7:1];
                            cmd_write_o <= 1'b1;
                            wr_data_o   <= {rx_bit, shreg[15:9]};
                            cmd_valid_o <= 1'b1;
                            state       <= ST_IDLE;
                        end
                    end
                    // Period floor of 190 us is the host's to keep
                    if (fall) begin
                        cnt <= 32'd0;
                    end
                    // A low past the break time restarts a cut frame
                    if (!line && !line_d && cnt >= N_BREAK) begin
                        armed <= 1'b1;
                        state <= ST_BREAK;
                    end
                end
                ST_WAIT: begin
                    // Response starts after the response delay
                    // Read data is taken once, two cycles after the strobe
                    if (cnt == 32'd1) begin
                        tx_byte <= rd_data_i;
                    end
                    if (cnt >= N_RSPS) begin
                        cnt     <= 32'd0;
                        bit_idx <= 5'd0;
                        state   <= ST_TXBIT;
                    end
                end
                ST_TXBIT: begin
                    // Fixed 205 us period; low length carries the bit
                    single_wire_data_line_oe_o <=
                        (cnt < (tx_byte[0] ? N_DW1 : N_DW0));
                    single_wire_data_line_o <= 1'b0;
                    if (cnt == N_CYCD - 32'd1) begin
                        cnt     <= 32'd0;
                        tx_byte <= {1'b0, tx_byte[7:1]};
                        bit_idx <= bit_idx + 5'd1;
                        if (bit_idx == 5'd7) begin
                            // Host turnaround is its own duty
                            single_wire_data_line_oe_o <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
                endcase
            end
        end
    end
endmodule // swl_link

// ---- src/swl_regs.vh ----
`ifndef SWL_REGS_VH
`define SWL_REGS_VH
// Clock cycles per microsecond (250 MHz)
`define SWL_US_CYCLES       250
// Times in microseconds, except the reset time in milliseconds
`define SWL_T_BREAK_US      190
`define SWL_T_BREAK_REC_US  40
`define SWL_T_HW1_MAX_US    50
`define SWL_T_HW0_MIN_US    86
`define SWL_T_CYCD_US       205
`define SWL_T_DW1_US        40
`define SWL_T_DW0_US        110
`define SWL_T_RSPS_US       300
`define SWL_T_RST_MS        2200
// Host bit threshold, halfway between the two host low widths
`define SWL_T_SPLIT_US      ((`SWL_T_HW1_MAX_US + `SWL_T_HW0_MIN_US) / 2)
// Long-low reset count at the full clock rate
`define SWL_N_RST           (`SWL_T_RST_MS * 1000 * `SWL_US_CYCLES)
// Frame layout
`define SWL_CMD_BITS        8
`define SWL_DATA_BITS       8
`define SWL_CMD_RW_BIT      7
`endif

// ---- src/swl_sync.v ----
module swl_sync (
    input  wire mclk_i,
    input  wire rst_b_i,
    input  wire din_i,
    output reg  dout_o
);
    reg s1;
    reg s2;
    reg s3;

    // Idle-high line; change accepted once stages two and three agree
    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s1     <= 1'b1;
            s2     <= 1'b1;
            s3     <= 1'b1;
            dout_o <= 1'b1;
        end else begin
            s1 <= din_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout_o <= s3;
            end
        end
    end
endmodule // swl_sync

// ---- verification/swl_host_model.sv ----
module swl_host_model #(
    parameter int US = 250
) (
    input  logic mclk_i,
    input  logic line_i,
    output logic drive_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial drive_o = 0;
    // Line changes on the falling edge, away from the sampling edge
    task automatic pull(input int lo, input int hi);
        @(negedge mclk_i) drive_o <= 1;
        repeat (lo) @(negedge mclk_i);
        drive_o <= 0;
        repeat (hi) @(negedge mclk_i);
    endtask
    task automatic brk;
        pull(192 * US, 42 * US);
    endtask
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            pull(b[i] ? 5 * US : 110 * US,
                 b[i] ? 187 * US : 82 * US);
    endtask
    task automatic recv(output logic [7:0] b);
        int n;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (line_i && n < 1200 * US) begin
                @(posedge mclk_i);
                n++;
            end
            n = 0;
            while (!line_i) begin
                @(posedge mclk_i);
                n++;
            end
            b[i] = n < 65 * US;
        end
        repeat (250 * US) @(posedge mclk_i);
    endtask
endmodule // swl_host_model

// ---- verification/swl_link_checker.sv ----
// ------
// Link checker
// ------
module swl_link_checker #(
    parameter RST_CYCLES = 2000,
    parameter US_CYCLES  = 250
) (
    input logic mclk_i,
    input logic rst_b_i,
    input logic sel_single_wire_i,
    input logic single_wire_data_line_i,
    input logic single_wire_data_line_o,
    input logic single_wire_data_line_oe_o,
    input logic single_wire_mode_o,
    input logic cmd_valid_o,
    input logic cmd_write_o,
    input logic device_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire oe = single_wire_data_line_oe_o;
    logic oe_d = 0;
    logic wait_rsp = 0;
    int lo_n = 0;
    int hl_n = 0;
    int rsp_n = 0;
    int per_n = 1000000;
    always @(posedge mclk_i) begin
        oe_d <= oe;
        lo_n <= oe ? lo_n + 1 : 0;
        hl_n <= (!single_wire_data_line_i && !oe) ? hl_n + 1 : 0;
        rsp_n <= wait_rsp ? rsp_n + 1 : 0;
        // Saturates so gaps between frames stay distinguishable
        per_n <= (oe && !oe_d) ? 1 : per_n + (per_n < 1000000);
        if (cmd_valid_o && !cmd_write_o)
            wait_rsp <= 1;
        else if (oe)
            wait_rsp <= 0;
    end
    property p_mode_set;
        sel_single_wire_i |=> single_wire_mode_o;
    endproperty
    a_mode_set: assert property (p_mode_set)
        else $error("mode not set");
    property p_mode_keep;
        single_wire_mode_o |=> single_wire_mode_o;
    endproperty
    a_mode_keep: assert property (p_mode_keep)
        else $error("mode lost");
    property p_quiet;
        !single_wire_mode_o |-> !oe && !cmd_valid_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("active outside mode");
    property p_drive_low;
        oe |-> !single_wire_data_line_o;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("drives high");
    property p_valid_pulse;
        cmd_valid_o |=> !cmd_valid_o;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("valid too long");
    property p_low_width;
        $fell(oe) && $past(rst_b_i) |->
            lo_n inside {[32 * US_CYCLES:50 * US_CYCLES],
                         [80 * US_CYCLES:145 * US_CYCLES]};
    endproperty
    a_low_width: assert property (p_low_width)
        else $error("bad low width");
    property p_period;
        $rose(oe) |-> lo_n == 0 &&
            (per_n inside {[190 * US_CYCLES:250 * US_CYCLES]} ||
             per_n > 1000 * US_CYCLES);
    endproperty
    a_period: assert property (p_period)
        else $error("bad bit period");
    property p_rsp;
        $rose(oe) && wait_rsp |->
            rsp_n inside {[190 * US_CYCLES:950 * US_CYCLES]};
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("bad response delay");
    property p_rst_cause;
        device_reset_o |-> hl_n >= RST_CYCLES;
    endproperty
    a_rst_cause: assert property (p_rst_cause)
        else $error("early reset");
    property p_rst_pulse;
        device_reset_o |=> !device_reset_o;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset too long");
endmodule // swl_link_checker

// ---- verification/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RST_N = 2000;
    // Shrunk microsecond scale keeps the run short
    localparam int US = 8;
    logic mclk = 0, rst_b = 0, sel = 0, v_wr;
    logic [7:0] rd = 0, got, v_dat;
    logic [6:0] v_addr;
    wire host_drv, line_o, oe, mode, valid, wr, dev_rst;
    wire [6:0] addr;
    wire [7:0] wdat;
    // Pull-up wins unless someone pulls low
    wire line = !host_drv && (!oe || line_o);
    int err_count = 0, cmp_count = 0, cyc = 0, rst_seen = 0, v_n = 0;
    // Row: command, data or reply, address, write
    logic [31:0] rows [2] = '{32'ha53c2501, 32'h12961200};
    initial forever #2 mclk = ~mclk;
    swl_link #(.RST_CYCLES(RST_N), .US_CYCLES(US)) dut (.mclk_i(mclk),
        .rst_b_i(rst_b), .sel_single_wire_i(sel),
        .single_wire_data_line_i(line),
        .single_wire_data_line_o(line_o), .single_wire_data_line_oe_o(oe),
        .single_wire_mode_o(mode), .cmd_valid_o(valid), .cmd_addr_o(addr),
        .cmd_write_o(wr), .wr_data_o(wdat), .rd_data_i(rd),
        .device_reset_o(dev_rst));
    swl_host_model #(.US(US)) host (.mclk_i(mclk), .line_i(line),
        .drive_o(host_drv));
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rst_seen <= rst_seen + dev_rst;
        if (valid === 1) begin
            v_addr <= addr;
            v_wr <= wr;
            v_dat <= wdat;
            v_n <= v_n + 1;
        end
        if (cyc == 100000) begin
            err_count++;
            summarize();
        end
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task summarize;
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge mclk);
        rst_b = 1;
        repeat (5) @(negedge mclk);
        chk("mode", 0, {7'h0, mode});
        // A full frame before selection must be ignored
        host.brk();
        host.send(8'h12);
        chk("count", 0, v_n[7:0]);
        sel = 1;
        @(negedge mclk);
        sel = 0;
        repeat (3) @(negedge mclk);
        chk("mode", 1, {7'h0, mode});
        foreach (rows[r]) begin
            rd = rows[r][23:16];
            host.brk();
            host.send(rows[r][31:24]);
            if (rows[r][0])
                host.send(rows[r][23:16]);
            chk("count", 8'(r + 1), v_n[7:0]);
            chk("addr", rows[r][15:8], {1'b0, v_addr});
            chk("write", rows[r][7:0], {7'h0, v_wr});
            if (rows[r][0])
                chk("data", rows[r][23:16], v_dat);
            else begin
                host.recv(got);
                chk("reply", rows[r][23:16], got);
            end
        end
        host.pull(RST_N + 100, 10);
        chk("reset", 1, rst_seen[7:0]);
        chk("mode", 1, {7'h0, mode});
        summarize();
    end
endmodule // tb
bind swl_link swl_link_checker #(.RST_CYCLES(RST_CYCLES),
    .US_CYCLES(US_CYCLES)) chk_i (.mclk_i,
    .rst_b_i, .sel_single_wire_i, .single_wire_data_line_i,
    .single_wire_data_line_o, .single_wire_data_line_oe_o,
    .single_wire_mode_o, .cmd_valid_o, .cmd_write_o, .device_reset_o);
